// ===== hdl/rtwa_fp_add.sv
// Single-precision adder, truncating, saturating, denormals as zero
`timescale 1ns/1ns
module rtwa_fp_add (
  rtwa_fp_if.op p
);
  typedef struct packed {
    logic [31:0] y;
    logic        sat;
  } rtwa_add_s;

  rtwa_add_s r;

  always_comb begin
    logic [31:0] big;
    logic [31:0] sml;
    logic [23:0] mb;
    logic [23:0] ms;
    logic [7:0]  diff;
    logic [24:0] s;
    logic [9:0]  e;
    big  = p.a;
    sml  = p.b;
    mb   = 24'h00_0000;
    ms   = 24'h00_0000;
    diff = 8'h00;
    s    = 25'h000_0000;
    e    = 10'h000;
    r    = '0;
    if (p.b[30:0] > p.a[30:0]) begin
      big = p.b;
      sml = p.a;
    end
    if (big[30:23] != 8'h00) begin
      mb   = {1'b1, big[22:0]};
      e    = {2'b00, big[30:23]};
      diff = big[30:23] - sml[30:23];
      // Small addends drop out below the total's resolution [R12]
      if (sml[30:23] != 8'h00 && diff < 8'd24) begin
        ms = {1'b1, sml[22:0]} >> diff;
      end
      if (big[31] == sml[31]) begin
        s = {1'b0, mb} + {1'b0, ms};
      end else begin
        s = {1'b0, mb} - {1'b0, ms};
      end
      if (s[24]) begin
        s = s >> 1;
        e = e + 10'h001;
      end
      for (int i = 0; i < 24; i++) begin
        if (!s[23] && e != 10'h000) begin
          s = s << 1;
          e = e - 10'h001;
        end
      end
      if (e >= rtwa_pkg::FP_EXP_TOP) begin
        r.y   = {big[31], rtwa_pkg::FP_MAX_MAG}; // [R5]
        r.sat = 1'b1;
      end else if (s[23] && e != 10'h000) begin
        r.y   = {big[31], e[7:0], s[22:0]};
        r.sat = {e[7:0], s[22:0]} == rtwa_pkg::FP_MAX_MAG; // [R5]
      end
    end
  end

  assign p.y   = r.y;
  assign p.sat = r.sat;
endmodule // rtwa_fp_add

// ===== hdl/rtwa_fp_if.sv
// Operand and result bundle of one single-precision operator
`timescale 1ns/1ns
interface rtwa_fp_if;
  logic [31:0] a;
  logic [31:0] b;
  logic [31:0] y;
  logic        sat;
  modport user (output a, output b, input y, input sat);
  modport op   (input a, input b, output y, output sat);
endinterface // rtwa_fp_if

// ===== hdl/rtwa_fp_mul.sv
// Single-precision multiplier, truncating, saturating, denormals as zero
`timescale 1ns/1ns
module rtwa_fp_mul (
  rtwa_fp_if.op p
);
  typedef struct packed {
    logic [31:0] y;
    logic        sat;
  } rtwa_mul_s;

  rtwa_mul_s r;

  always_comb begin
    logic [47:0] prod;
    logic [9:0]  e;
    logic [22:0] frac;
    logic        sgn;
    prod = 48'h0000_0000_0000;
    e    = 10'h000;
    frac = 23'h00_0000;
    sgn  = p.a[31] ^ p.b[31];
    r    = '0;
    if (p.a[30:23] != 8'h00 && p.b[30:23] != 8'h00) begin
      prod = {1'b1, p.a[22:0]} * {1'b1, p.b[22:0]};
      e    = {2'b00, p.a[30:23]} + {2'b00, p.b[30:23]} - rtwa_pkg::FP_BIAS;
      if (prod[47]) begin
        frac = prod[46:24];
        e    = e + 10'h001;
      end else begin
        frac = prod[45:23];
      end
      if (!e[9] && e >= rtwa_pkg::FP_EXP_TOP) begin
        r.y   = {sgn, rtwa_pkg::FP_MAX_MAG};
        r.sat = 1'b1;
      end else if (!e[9] && e != 10'h000) begin
        r.y = {sgn, e[7:0], frac};
      end
    end
  end

  assign p.y   = r.y;
  assign p.sat = r.sat;
endmodule // rtwa_fp_mul

// ===== hdl/rtwa_pkg.sv
// Constants, register map and field layout of the rate totalizer
package rtwa_pkg;
  localparam logic [7:0]  OFF_CTRL       = 8'h00;
  localparam logic [7:0]  OFF_DEC        = 8'h04;
  localparam logic [7:0]  OFF_THRESH     = 8'h08;
  localparam logic [7:0]  OFF_TOTAL      = 8'h0C;
  localparam logic [7:0]  OFF_STATUS     = 8'h10;
  localparam logic [7:0]  OFF_IRQ_STAT   = 8'h14;
  localparam logic [7:0]  OFF_IRQ_MASK   = 8'h18;

  localparam int          CTRL_RUN_BIT    = 0;
  localparam int          CTRL_FREEZE_BIT = 1;
  localparam int          CTRL_CLEAR_BIT  = 2;
  localparam int          STAT_ALARM_BIT  = 0;
  localparam int          STAT_ACTIVE_BIT = 1;
  localparam int          STAT_GOOD_BIT   = 2;
  localparam int          IRQ_ALARM_BIT   = 0;
  localparam int          IRQ_SAT_BIT     = 1;

  localparam logic [2:0]  CTRL_RESET     = 3'h0;
  localparam logic [2:0]  DEC_RESET      = 3'h0;
  localparam logic [2:0]  DEC_MAX        = 3'h4;
  localparam logic [31:0] THRESH_RESET   = 32'h0000_0000;
  localparam logic [31:0] TOTAL_RESET    = 32'h0000_0000;
  localparam logic [1:0]  IRQ_RESET      = 2'h0;

  // Largest finite single-precision magnitude, sign excluded
  localparam logic [30:0] FP_MAX_MAG     = 31'h7F7F_FFFF;
  localparam logic [9:0]  FP_BIAS        = 10'h07F;
  localparam logic [9:0]  FP_EXP_TOP     = 10'h0FF;

  localparam int          CLK_PERIOD_NS  = 50;
  localparam int          TICK_PERIOD_NS = 1000000;
  localparam int          TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  // Tick period in seconds, 0.001 as single precision
  localparam logic [31:0] TICK_PERIOD_FP = 32'h3A83_126F;
endpackage

// ===== hdl/rtwa_top.sv
// Rate totalizer with threshold alarm, APB register slave and interrupt
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// Contract
// [R1] Positive threshold: alarm while total is strictly above it.
// [R2] Negative threshold: alarm while total is strictly below it.
// [R3] Threshold of zero disables the alarm entirely.
// [R4] Reset, run removal or a threshold write clears the alarm.
// [R5] Total saturates at the largest finite single-precision values.
// [R6] Bad input status stops accumulation; total stays put.
// [R7] Decimal places select 0 to 4, reset value 0.
// [R8] Integrate only with run on and freeze off.
// [R9] Freeze holds the total at its present value.
// [R10] Run 1 requests totalizing, 0 stops it; default 0.
// [R11] Alarm is a read-only bit, 0 off, 1 on.
// [R12] Increments below the total's resolution may be lost.
// [R13] While running, integrate continuously and test the alarm continuously.
// [R14] While frozen, keep testing the alarm against the held total.
// [R15] Totalizer reset zeroes the total and clears the alarm.
// [R16] Each tick adds input times tick period in single precision.
module rtwa_top #(
  parameter int TICK_CYCLES = rtwa_pkg::TICK_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [31:0] rate_value,
  input  wire logic        rate_good,
  input  wire logic        run_in,
  input  wire logic        freeze_control,
  input  wire logic        clear_in,
  output logic      [31:0] total_value,
  output logic             alarm_flag,
  output logic      [2:0]  decimal_places_select,
  output logic             irq
);

  //////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [31:0] total;
    logic        alarm;
    logic [2:0]  ctrl;
    logic [2:0]  dec;
    logic [31:0] thresh;
    logic [15:0] tick_cnt;
    logic        tick;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic        irq;
  } rtwa_state_s;

  rtwa_state_s s;
  rtwa_state_s next_s;

  //////////////////////////////////////////////////////////////////////////////
  // Arithmetic

  rtwa_fp_if mul_bus ();
  rtwa_fp_if add_bus ();

  rtwa_fp_mul u_mul (
    .p (mul_bus.op)
  );

  rtwa_fp_add u_add (
    .p (add_bus.op)
  );

  // Input times tick period, then added onto the total [R16]
  assign mul_bus.a = rate_value;
  assign mul_bus.b = rtwa_pkg::TICK_PERIOD_FP;
  assign add_bus.a = s.total;
  assign add_bus.b = mul_bus.y;

  //////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Maps a float onto an unsigned key with the same ordering
  function automatic logic [31:0] rtwa_order_key(input logic [31:0] f);
    logic [31:0] k;
    k = f[31] ? ~f : {1'b1, f[30:0]};
    return k;
  endfunction

  logic run_eff;
  logic freeze_eff;
  logic clear_eff;
  logic active;
  logic accumulate;
  logic thresh_zero;
  logic alarm_cond;
  logic apb_access;
  logic apb_done;
  logic wr_done;
  logic addr_hit;
  logic thresh_wr;
  logic sat_event;
  logic [31:0] rd_mux;
  logic [31:0] key_total;
  logic [31:0] key_thresh;

  // Wired controls and register controls act alike
  assign run_eff    = run_in | s.ctrl[rtwa_pkg::CTRL_RUN_BIT];                   // [R10]
  assign freeze_eff = freeze_control | s.ctrl[rtwa_pkg::CTRL_FREEZE_BIT];        // [R9]
  assign clear_eff  = clear_in | s.ctrl[rtwa_pkg::CTRL_CLEAR_BIT];
  assign active     = run_eff & ~freeze_eff & ~clear_eff;                        // [R8]
  assign accumulate = active & s.tick & rate_good;                               // [R6] [R13]

  assign key_total   = rtwa_order_key(s.total);
  assign key_thresh  = rtwa_order_key(s.thresh);
  // Negative zero counts as zero too
  assign thresh_zero = s.thresh[30:0] == 31'h0000_0000;                          // [R3]
  always_comb begin
    if (thresh_zero) begin
      alarm_cond = 1'b0;                                                         // [R3]
    end else if (!s.thresh[31]) begin
      alarm_cond = key_total > key_thresh;                                       // [R1]
    end else begin
      alarm_cond = key_total < key_thresh;                                       // [R2]
    end
  end

  assign apb_access = psel & penable;
  assign apb_done   = apb_access & s.pready;
  assign wr_done    = apb_done & pwrite;
  assign thresh_wr  = wr_done & (paddr == rtwa_pkg::OFF_THRESH);
  assign sat_event  = accumulate & add_bus.sat;

  always_comb begin
    addr_hit = 1'b1;
    rd_mux   = 32'h0000_0000;
    unique case (paddr)
      rtwa_pkg::OFF_CTRL: begin
        rd_mux[2:0] = s.ctrl;
      end
      rtwa_pkg::OFF_DEC: begin
        rd_mux[2:0] = s.dec;
      end
      rtwa_pkg::OFF_THRESH: begin
        rd_mux = s.thresh;
      end
      rtwa_pkg::OFF_TOTAL: begin
        rd_mux = s.total;
      end
      rtwa_pkg::OFF_STATUS: begin
        rd_mux[rtwa_pkg::STAT_ALARM_BIT]  = s.alarm;                             // [R11]
        rd_mux[rtwa_pkg::STAT_ACTIVE_BIT] = active;
        rd_mux[rtwa_pkg::STAT_GOOD_BIT]   = rate_good;
      end
      rtwa_pkg::OFF_IRQ_STAT: begin
        rd_mux[1:0] = s.irq_stat;
      end
      rtwa_pkg::OFF_IRQ_MASK: begin
        rd_mux[1:0] = s.irq_mask;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_s = s;

    // Free-running tick every TICK_CYCLES cycles; a value of 1 ticks every cycle
    next_s.tick = 1'b0;
    if (s.tick_cnt == 16'(TICK_CYCLES - 1)) begin
      next_s.tick_cnt = 16'h0000;
      next_s.tick     = 1'b1;
    end else begin
      next_s.tick_cnt = s.tick_cnt + 16'h0001;
    end

    // Total
    if (clear_eff) begin
      next_s.total = rtwa_pkg::TOTAL_RESET;                                      // [R15]
    end else if (accumulate) begin
      next_s.total = add_bus.y;                                                  // [R5] [R16]
    end

    // Alarm follows the held total while frozen, drops on any clearing event
    if (clear_eff || !run_eff || thresh_wr) begin
      next_s.alarm = 1'b0;                                                       // [R4] [R15]
    end else begin
      next_s.alarm = alarm_cond;                                                 // [R13] [R14]
    end

    // APB: one wait state, so read data can come from a flop
    next_s.pready  = apb_access & ~s.pready;
    next_s.pslverr = 1'b0;
    if (apb_access && !s.pready) begin
      next_s.prdata  = pwrite ? 32'h0000_0000 : rd_mux;
      next_s.pslverr = ~addr_hit;
    end

    if (wr_done) begin
      unique case (paddr)
        rtwa_pkg::OFF_CTRL: begin
          next_s.ctrl = pwdata[2:0];                                             // [R10]
        end
        rtwa_pkg::OFF_DEC: begin
          // Out-of-range codes leave the setting unchanged
          if (pwdata[31:0] <= {29'h0000_0000, rtwa_pkg::DEC_MAX}) begin
            next_s.dec = pwdata[2:0];                                            // [R7]
          end
        end
        rtwa_pkg::OFF_THRESH: begin
          next_s.thresh = pwdata;
        end
        rtwa_pkg::OFF_IRQ_MASK: begin
          next_s.irq_mask = pwdata[1:0];
        end
        default: begin
          next_s.ctrl = s.ctrl;
        end
      endcase
    end

    // Sticky events; a new event wins over a write-one clear
    if (wr_done && paddr == rtwa_pkg::OFF_IRQ_STAT) begin
      next_s.irq_stat = s.irq_stat & ~pwdata[1:0];
    end
    if (next_s.alarm && !s.alarm) begin
      next_s.irq_stat[rtwa_pkg::IRQ_ALARM_BIT] = 1'b1;
    end
    if (sat_event) begin
      next_s.irq_stat[rtwa_pkg::IRQ_SAT_BIT] = 1'b1;
    end
    next_s.irq = |(next_s.irq_stat & next_s.irq_mask);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk) begin
    if (rst) begin
      s          <= '0;
      s.total    <= rtwa_pkg::TOTAL_RESET;
      s.ctrl     <= rtwa_pkg::CTRL_RESET;                                        // [R10]
      s.dec      <= rtwa_pkg::DEC_RESET;                                         // [R7]
      s.thresh   <= rtwa_pkg::THRESH_RESET;
      s.irq_stat <= rtwa_pkg::IRQ_RESET;
      s.irq_mask <= rtwa_pkg::IRQ_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign prdata                = s.prdata;
  assign pready                = s.pready;
  assign pslverr               = s.pslverr;
  assign total_value           = s.total;
  assign alarm_flag            = s.alarm;                                        // [R11]
  assign decimal_places_select = s.dec;
  assign irq                   = s.irq;

endmodule // rtwa_top

// ===== verif/rtwa_top_asserts.sv
// Port-level assertions of the rate totalizer
`timescale 1ns/1ns
module rtwa_top_asserts #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rate_good,
  input wire logic        freeze_control,
  input wire logic        clear_in,
  input wire logic [31:0] total_value,
  input wire logic        alarm_flag,
  input wire logic [2:0]  decimal_places_select
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////////
  property p_clear_total; clear_in |=> total_value == 32'h0000_0000; endproperty
  a_clear_total: assert property (p_clear_total) else $error("total kept on clear");
  property p_clear_alarm; clear_in [*2] |-> !alarm_flag; endproperty
  a_clear_alarm: assert property (p_clear_alarm) else $error("alarm kept on clear");
  property p_freeze_hold;
    (freeze_control && !clear_in) [*2] |-> $stable(total_value);
  endproperty
  a_freeze_hold: assert property (p_freeze_hold) else $error("total moved in freeze");
  property p_bad_hold; (!rate_good && !clear_in) [*2] |-> $stable(total_value); endproperty
  a_bad_hold: assert property (p_bad_hold) else $error("total moved on bad input");
  property p_sat_bound; total_value[30:0] <= rtwa_pkg::FP_MAX_MAG; endproperty
  a_sat_bound: assert property (p_sat_bound) else $error("total beyond finite range");
  property p_dec_range; decimal_places_select <= rtwa_pkg::DEC_MAX; endproperty
  a_dec_range: assert property (p_dec_range) else $error("decimal places out of range");
  // Clear may zero the total at any cycle, so it aborts the check
  property p_tick_gap;
    disable iff (rst || clear_in)
    ($changed(total_value) && !$past(clear_in)) |=> $stable(total_value) [*2];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("total updated between ticks");
  property p_one_wait; (psel && penable && !$past(penable)) |-> !pready ##1 pready; endproperty
  a_one_wait: assert property (p_one_wait) else $error("access not one wait state");
  property p_err_ready; pslverr |-> pready && psel && penable; endproperty
  a_err_ready: assert property (p_err_ready) else $error("error outside completion");
  // Threshold write drops the alarm for at least the following cycle
  property p_thresh_clear;
    (psel && penable && pready && pwrite && paddr == rtwa_pkg::OFF_THRESH) |=> !alarm_flag;
  endproperty
  a_thresh_clear: assert property (p_thresh_clear) else $error("alarm kept on threshold write");

  c_alarm: cover property (alarm_flag);
  c_err: cover property (pslverr);
  c_sat: cover property (total_value == 32'h7F7F_FFFF);
endmodule // rtwa_top_asserts

bind rtwa_top rtwa_top_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_rtwa_top_asserts (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pready(pready),
  .pslverr(pslverr), .rate_good(rate_good), .freeze_control(freeze_control),
  .clear_in(clear_in), .total_value(total_value), .alarm_flag(alarm_flag),
  .decimal_places_select(decimal_places_select));

// ===== verif/tb.sv
// Self-checking testbench of the rate totalizer
`timescale 1ns/1ns
module tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] rate_value = 32'h447A_0000;
  logic        rate_good = 1'b1;
  logic        run_in = 1'b0;
  logic        freeze_control = 1'b0;
  logic        clear_in = 1'b0;
  logic [31:0] total_value;
  logic        alarm_flag;
  logic [2:0]  decimal_places_select;
  logic        irq;
  logic [32:0] exp_q[$];
  int          n_mismatch = 0;
  int          samples_checked = 0;
  logic [31:0] v;
  logic [31:0] dec;
  logic [31:0] thr[3] = '{32'hBF80_0000, 32'h0000_0000, 32'h8000_0000};

  rtwa_top #(.TICK_CYCLES(4)) u_rtwa_top (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rate_value(rate_value), .rate_good(rate_good),
    .run_in(run_in), .freeze_control(freeze_control), .clear_in(clear_in),
    .total_value(total_value), .alarm_flag(alarm_flag),
    .decimal_places_select(decimal_places_select), .irq(irq));

  always #25 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  task report_and_stop;
    if (n_mismatch == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task check(input logic [32:0] seen, input logic [32:0] want);
    samples_checked++;
    if (seen !== want) begin
      n_mismatch++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask

  // Called just after a rising edge; request held until pready sampled
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      n_mismatch++;
      report_and_stop();
    end
    // Idle edge, so the next setup never re-drives psel in this time step
    @(posedge clk);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a, input logic [32:0] want);
    exp_q.push_back(want);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  task waitv(input logic [31:0] want);
    int k;
    for (k = 0; k < 8000 && total_value !== want; k++) @(posedge clk);
    if (total_value !== want) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask

  // Completion of each read carries the result to compare
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) check({pslverr, prdata}, exp_q.pop_front());
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h6aa5_efa9));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(rtwa_pkg::OFF_CTRL, 33'h0);
    rd(rtwa_pkg::OFF_TOTAL, 33'h0);
    rd(rtwa_pkg::OFF_STATUS, 33'h4);
    rd(8'h40, {1'b1, 32'h0000_0000});
    dec = 32'h0;
    for (int i = 0; i < 12; i++) begin
      v = (i < 5) ? 32'(i) : 32'($urandom % 8);
      wr(rtwa_pkg::OFF_DEC, v);
      if (v <= 32'h4) dec = v;
      rd(rtwa_pkg::OFF_DEC, {1'b0, dec});
      check(decimal_places_select, dec);
    end
    wr(rtwa_pkg::OFF_THRESH, 32'h3F80_0000);
    wr(rtwa_pkg::OFF_IRQ_MASK, 32'h1);
    wr(rtwa_pkg::OFF_CTRL, 32'h1);
    waitv(32'h4000_0000);
    freeze_control <= 1'b1;
    repeat (12) @(posedge clk);
    rd(rtwa_pkg::OFF_TOTAL, 33'h0_4000_0000);
    rd(rtwa_pkg::OFF_STATUS, 33'h5);
    check(irq, 1'b1);
    check(alarm_flag, 1'b1);
    wr(rtwa_pkg::OFF_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clk);
    check(irq, 1'b0);
    wr(rtwa_pkg::OFF_IRQ_MASK, 32'h1);
    wr(rtwa_pkg::OFF_IRQ_STAT, 32'h1);
    repeat (2) @(posedge clk);
    check(irq, 1'b0);
    rate_good <= 1'b0;
    freeze_control <= 1'b0;
    repeat (12) @(posedge clk);
    rd(rtwa_pkg::OFF_TOTAL, 33'h0_4000_0000);
    rate_good <= 1'b1;
    waitv(32'h4040_0000);
    freeze_control <= 1'b1;
    wr(rtwa_pkg::OFF_THRESH, 32'h40A0_0000);
    rd(rtwa_pkg::OFF_STATUS, 33'h4);
    check(alarm_flag, 1'b0);
    foreach (thr[i]) begin
      wr(rtwa_pkg::OFF_THRESH, thr[i]);
      rd(rtwa_pkg::OFF_STATUS, 33'h4);
    end
    wr(rtwa_pkg::OFF_CTRL, 32'h0);
    clear_in <= 1'b1;
    repeat (2) @(posedge clk);
    clear_in <= 1'b0;
    rd(rtwa_pkg::OFF_TOTAL, 33'h0);
    rate_value <= 32'hC47A_0000;
    wr(rtwa_pkg::OFF_THRESH, 32'hBFC0_0000);
    freeze_control <= 1'b0;
    run_in <= 1'b1;
    waitv(32'hC000_0000);
    freeze_control <= 1'b1;
    repeat (4) @(posedge clk);
    rd(rtwa_pkg::OFF_STATUS, 33'h5);
    check(alarm_flag, 1'b1);
    run_in <= 1'b0;
    repeat (2) @(posedge clk);
    rd(rtwa_pkg::OFF_STATUS, 33'h4);
    wr(rtwa_pkg::OFF_THRESH, 32'h0);
    clear_in <= 1'b1;
    @(posedge clk);
    clear_in <= 1'b0;
    freeze_control <= 1'b0;
    rate_value <= 32'h7F7F_FFFF;
    run_in <= 1'b1;
    waitv(32'h7F7F_FFFF);
    repeat (8) @(posedge clk);
    rd(rtwa_pkg::OFF_TOTAL, 33'h0_7F7F_FFFF);
    rd(rtwa_pkg::OFF_IRQ_STAT, 33'h3);
    // Register clear and register freeze act like the wired ones
    wr(rtwa_pkg::OFF_CTRL, 32'h4);
    rd(rtwa_pkg::OFF_TOTAL, 33'h0);
    rd(rtwa_pkg::OFF_STATUS, 33'h4);
    wr(rtwa_pkg::OFF_CTRL, 32'h2);
    rd(rtwa_pkg::OFF_CTRL, 33'h2);
    rd(rtwa_pkg::OFF_STATUS, 33'h4);
    rd(rtwa_pkg::OFF_TOTAL, 33'h0);
    report_and_stop();
  end
endmodule // tb
